// ---- rtl/math_slave_coprocessor.sv ----
// Slave arithmetic unit with a classic Wishbone register and operand port
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module math_slave_coprocessor #(
  parameter int ADR_W = 19
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic busy_o,
  output logic complete_irq_o,
  output logic error_irq_o
);
  localparam int WB = mc_pkg::WINDOW_BIT;

  typedef enum logic [1:0] {st_idle, st_exec, st_divide, st_root} state_t;
  typedef struct packed {
    state_t st;
    logic [15:0][7:0] mem;
    mc_pkg::opcode_t op;
    logic [7:0] base_low;
    logic [7:0] base_high;
    logic busy;
    logic done_ok;
    logic done_err;
    logic [7:0] result;
    logic ack;
    logic [31:0] dat;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] sh;
    logic [31:0] den;
    logic [5:0] cnt;
    logic [48:0] rad;
    logic [48:0] root;
    logic [48:0] bitm;
    logic sgn;
    logic signed [11:0] exq;
  } unit_t;

  unit_t s;
  unit_t next_s;

  // ----------------------------------------------------------------
  // Float helpers
  // ----------------------------------------------------------------
  // Bring the top set bit to bit 23; exponent grows with its position
  function automatic logic [35:0] norm(input logic [47:0] v, input logic signed [11:0] eb);
    int p;
    logic [47:0] m;
    p = 0;
    for (int i = 0; i < 48; i++) begin
      if (v[i]) p = i;
    end
    if (p >= mc_pkg::FRAC_W) m = v >> (p - mc_pkg::FRAC_W);
    else m = v << (mc_pkg::FRAC_W - p);
    return {eb + 12'(p), m[23:0]};
  endfunction : norm

  // Range check and packing; denormals are not produced
  function automatic logic [34:0] pack(input logic sg, input logic [35:0] em);
    logic signed [11:0] e;
    e = em[35:24];
    if (em[23:0] == 24'h0) return {mc_pkg::ERR_NONE, 32'h0};
    if (e >= 12'(mc_pkg::EXP_TOP)) return {mc_pkg::ERR_OVERFLOW, 32'h0};
    if (e <= 12'sh0) return {mc_pkg::ERR_UNDERFLOW, 32'h0};
    return {mc_pkg::ERR_NONE, sg, e[7:0], em[22:0]};
  endfunction : pack

  // Ordered key; both zeros map alike
  function automatic logic [31:0] key(input logic [31:0] x);
    if (x[30:23] == 8'h0) return 32'h8000_0000;
    if (x[31]) return ~x;
    return {1'b1, x[30:0]};
  endfunction : key

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic io_hit, win_hit, wr, op_wr, fin, fput, fsg, qb, odd;
  logic [2:0] idx, err, rel;
  logic [31:0] a1, a2, b, big, sml, mag, k1, k2;
  logic [7:0] e1, eb, ebig, esml;
  logic [23:0] m1, mb, mbig, msml;
  logic [26:0] al;
  logic [27:0] sum;
  logic [32:0] t;
  logic [48:0] trial;
  logic [35:0] fem;
  logic [34:0] pk;
  logic signed [11:0] te;
  int ex;

  always_comb begin
    next_s = s;
    fin = 1'b0;
    fput = 1'b0;
    fsg = 1'b0;
    fem = '0;
    pk = '0;
    err = mc_pkg::ERR_NONE;
    rel = 3'h0;
    qb = 1'b0;
    t = '0;
    trial = '0;
    ex = 0;
    te = '0;
    mag = '0;
    sum = '0;
    al = '0;
    a1 = s.mem[3:0];
    a2 = s.mem[7:4];
    // Second operand, picked per operation
    b = (s.op == mc_pkg::real_squaring_op) ? a1 : a2;
    if (s.op == mc_pkg::real_difference_op) b[31] = ~b[31];
    e1 = a1[30:23];
    eb = b[30:23];
    m1 = (e1 == 8'h0) ? 24'h0 : {1'b1, a1[22:0]};
    mb = (eb == 8'h0) ? 24'h0 : {1'b1, b[22:0]};
    odd = ~e1[0];
    big = (a1[30:0] >= b[30:0]) ? a1 : b;
    sml = (a1[30:0] >= b[30:0]) ? b : a1;
    ebig = big[30:23];
    esml = sml[30:23];
    mbig = (ebig == 8'h0) ? 24'h0 : {1'b1, big[22:0]};
    msml = (esml == 8'h0) ? 24'h0 : {1'b1, sml[22:0]};
    k1 = key(a1);
    k2 = key(a2);

    // Bus decode; one cycle answer, dropped the cycle after
    idx = adr_i[4:2];
    io_hit = !adr_i[WB] && (adr_i[WB-1:5] == '0);
    win_hit = adr_i[WB] && (adr_i[WB-1:6] == {s.base_high, s.base_low[7:4]});
    next_s.ack = cyc_i && stb_i && !s.ack;
    next_s.dat = '0;
    if (io_hit && idx == mc_pkg::RESULT_IDX) next_s.dat[7:0] = s.result;
    if (io_hit && idx == mc_pkg::STATUS_IDX) next_s.dat[7:0] = {5'h0, s.done_err, s.done_ok, s.busy};
    if (win_hit && !adr_i[5]) next_s.dat[7:0] = s.mem[adr_i[5:2]];

    // Writes take effect on the edge that sees ack
    wr = cyc_i && stb_i && we_i && s.ack && sel_i[0];
    op_wr = wr && io_hit && idx == mc_pkg::OPCODE_IDX;
    if (op_wr && !s.busy) begin
      next_s.op = mc_pkg::opcode_t'(dat_i[3:0]);
      next_s.busy = 1'b1;
      next_s.done_ok = 1'b0;
      next_s.done_err = 1'b0;
      next_s.st = st_exec;
    end
    // Base low nibble forced to zero so the window stays aligned
    if (wr && io_hit && idx == mc_pkg::RESULT_IDX) next_s.base_low = {dat_i[7:4], 4'h0};
    if (wr && io_hit && idx == mc_pkg::BASE_HIGH_IDX) next_s.base_high = dat_i[7:0];
    // Upper eight locations are reserved and not stored
    if (wr && win_hit && !adr_i[5] && !s.busy) next_s.mem[adr_i[5:2]] = dat_i[7:0];

    // Execution runs on its own, no bus involvement
    case (s.st)
      st_exec: begin
        case (s.op)
          mc_pkg::int_product_op: begin
            next_s.mem[3:0] = 32'(a1[15:0]) * 32'(a2[15:0]);
            fin = 1'b1;
          end
          mc_pkg::int_quotient_op, mc_pkg::wide_int_quotient_op: begin
            if (a2[15:0] == 16'h0) begin
              err = mc_pkg::ERR_DIV_ZERO;
              fin = 1'b1;
            end else begin
              next_s.rem = '0;
              next_s.quo = '0;
              next_s.cnt = '0;
              next_s.den = {16'h0, a2[15:0]};
              next_s.sh = (s.op == mc_pkg::int_quotient_op) ? {16'h0, a1[15:0]} : a1;
              next_s.st = st_divide;
            end
          end
          mc_pkg::real_quotient_op: begin
            if (mb == 24'h0) begin
              err = mc_pkg::ERR_DIV_ZERO;
              fin = 1'b1;
            end else if (m1 == 24'h0) begin
              next_s.mem[3:0] = 32'h0;
              fin = 1'b1;
            end else begin
              // Half the dividend keeps the quotient inside 32 bits
              next_s.rem = {9'h0, m1[23:1]};
              next_s.sh = {m1[0], 31'h0};
              next_s.den = {8'h0, mb};
              next_s.quo = '0;
              next_s.cnt = '0;
              next_s.sgn = a1[31] ^ b[31];
              next_s.exq = 12'(int'(e1) - int'(eb) - 31 + mc_pkg::BIAS);
              next_s.st = st_divide;
            end
          end
          mc_pkg::real_product_op, mc_pkg::real_squaring_op: begin
            fput = 1'b1;
            fsg = a1[31] ^ b[31];
            fem = norm(48'(m1) * 48'(mb), 12'(int'(e1) + int'(eb) - mc_pkg::BIAS - 2 * mc_pkg::FRAC_W));
          end
          mc_pkg::real_sum_op, mc_pkg::real_difference_op: begin
            // Three guard bits; the rest truncate
            al = {msml, 3'h0} >> (ebig - esml);
            if (big[31] == sml[31]) sum = {1'b0, mbig, 3'h0} + {1'b0, al};
            else sum = {1'b0, mbig, 3'h0} - {1'b0, al};
            fput = 1'b1;
            fsg = big[31];
            fem = norm({20'h0, sum}, 12'(int'(ebig) - mc_pkg::FRAC_W - 3));
          end
          mc_pkg::real_root_op: begin
            if (a1[31] && m1 != 24'h0) begin
              err = mc_pkg::ERR_NEG_ROOT;
              fin = 1'b1;
            end else if (m1 == 24'h0) begin
              next_s.mem[3:0] = 32'h0;
              fin = 1'b1;
            end else begin
              // Odd exponent folds one bit into the radicand
              next_s.rad = odd ? {1'b0, m1, 24'h0} : {2'h0, m1, 23'h0};
              te = 12'(int'(e1) - mc_pkg::BIAS - int'(odd));
              next_s.exq = (te >>> 1) + 12'(mc_pkg::BIAS);
              next_s.root = '0;
              next_s.bitm = mc_pkg::ROOT_FIRST_BIT;
              next_s.st = st_root;
            end
          end
          mc_pkg::int_to_real_op: begin
            mag = a1[31] ? (~a1 + 32'h1) : a1;
            fput = 1'b1;
            fsg = a1[31];
            fem = norm({16'h0, mag}, 12'(mc_pkg::BIAS));
          end
          mc_pkg::real_to_int_op: begin
            ex = int'(e1) - mc_pkg::BIAS;
            if (m1 == 24'h0 || ex < 0) begin
              next_s.mem[3:0] = 32'h0;
            end else if (ex > mc_pkg::INT_TOP_EXP) begin
              err = mc_pkg::ERR_OVERFLOW;
            end else begin
              if (ex >= mc_pkg::FRAC_W) mag = {8'h0, m1} << (ex - mc_pkg::FRAC_W);
              else mag = {8'h0, m1} >> (mc_pkg::FRAC_W - ex);
              next_s.mem[3:0] = a1[31] ? (~mag + 32'h1) : mag;
            end
            fin = 1'b1;
          end
          mc_pkg::real_relation_op, mc_pkg::real_zero_check_op: begin
            if (s.op == mc_pkg::real_zero_check_op) k2 = key(32'h0);
            if (k1 == k2) rel = mc_pkg::REL_EQ;
            else if (k1 > k2) rel = mc_pkg::REL_GT;
            else rel = mc_pkg::REL_LT;
            fin = 1'b1;
          end
          mc_pkg::argument_swap_op: begin
            next_s.mem[3:0] = a2;
            next_s.mem[7:4] = a1;
            fin = 1'b1;
          end
          default: begin
            fin = 1'b1;
          end
        endcase
      end
      st_divide: begin
        // Restoring divider, one quotient bit a cycle
        t = {s.rem, s.sh[31]};
        if (t >= {1'b0, s.den}) begin
          next_s.rem = 32'(t - {1'b0, s.den});
          qb = 1'b1;
        end else begin
          next_s.rem = t[31:0];
        end
        next_s.sh = {s.sh[30:0], 1'b0};
        next_s.quo = {s.quo[30:0], qb};
        next_s.cnt = s.cnt + 6'h1;
        if (s.cnt == mc_pkg::DIV_LAST) begin
          if (s.op == mc_pkg::real_quotient_op) begin
            fput = 1'b1;
            fsg = s.sgn;
            fem = norm({16'h0, next_s.quo}, s.exq);
          end else begin
            next_s.mem[3:0] = next_s.quo;
            next_s.mem[7:4] = next_s.rem;
            fin = 1'b1;
          end
        end
      end
      st_root: begin
        // Digit by digit root, two radicand bits a cycle
        trial = s.root + s.bitm;
        if (s.rad >= trial) begin
          next_s.rad = s.rad - trial;
          next_s.root = (s.root >> 1) + s.bitm;
        end else begin
          next_s.root = s.root >> 1;
        end
        next_s.bitm = s.bitm >> 2;
        if (s.bitm == 49'h1) begin
          fput = 1'b1;
          fem = {s.exq, next_s.root[23:0]};
        end
      end
      default: begin
      end
    endcase

    // Float results are written only when in range
    if (fput) begin
      pk = pack(fsg, fem);
      err = pk[34:32];
      if (pk[34:32] == mc_pkg::ERR_NONE) next_s.mem[3:0] = pk[31:0];
      fin = 1'b1;
    end
    // Busy drops in the cycle the done flag rises
    if (fin) begin
      next_s.busy = 1'b0;
      next_s.done_ok = (err == mc_pkg::ERR_NONE);
      next_s.done_err = (err != mc_pkg::ERR_NONE);
      next_s.result = {rel, 2'h0, err};
      next_s.st = st_idle;
    end
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.base_low <= mc_pkg::BASE_RESET;
      s.base_high <= mc_pkg::BASE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Done flags double as the two interrupt lines
  assign dat_o = s.dat;
  assign ack_o = s.ack;
  assign busy_o = s.busy;
  assign complete_irq_o = s.done_ok;
  assign error_irq_o = s.done_err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] busy_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || !s.busy) busy_len <= 16'h0;
    else busy_len <= busy_len + 16'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_accept;
    op_wr && !s.busy |=> s.busy && s.st == st_exec;
  endproperty
  a_accept: assert property (p_accept) else $error("opcode not accepted");
  property p_refuse;
    op_wr && s.busy |=> s.op == $past(s.op);
  endproperty
  a_refuse: assert property (p_refuse) else $error("opcode taken while busy");
  property p_drop;
    $fell(busy_o) |-> (complete_irq_o ^ error_irq_o);
  endproperty
  a_drop: assert property (p_drop) else $error("busy fell without one done flag");
  property p_raise;
    $rose(s.done_ok) || $rose(s.done_err) |-> !s.busy && $past(s.busy);
  endproperty
  a_raise: assert property (p_raise) else $error("done flag without busy end");
  property p_limit;
    s.busy |-> busy_len <= 16'(mc_pkg::limit_cycles(s.op));
  endproperty
  a_limit: assert property (p_limit) else $error("operation over its time limit");
  property p_ok_code;
    s.done_ok |-> s.result[2:0] == mc_pkg::ERR_NONE;
  endproperty
  a_ok_code: assert property (p_ok_code) else $error("complete with error code");
  property p_err_code;
    s.done_err |-> s.result[2:0] != mc_pkg::ERR_NONE;
  endproperty
  a_err_code: assert property (p_err_code) else $error("error flag with no code");
  property p_product;
    $rose(s.done_ok) && s.op == mc_pkg::int_product_op |-> a1 == 32'($past(a1[15:0])) * 32'($past(a2[15:0]));
  endproperty
  a_product: assert property (p_product) else $error("wrong integer product");
  property p_swap;
    $rose(s.done_ok) && s.op == mc_pkg::argument_swap_op |-> a1 == $past(a2) && a2 == $past(a1);
  endproperty
  a_swap: assert property (p_swap) else $error("arguments not swapped");
  property p_rel;
    $rose(s.done_ok) && (s.op == mc_pkg::real_relation_op || s.op == mc_pkg::real_zero_check_op)
      |-> $onehot(s.result[7:5]);
  endproperty
  a_rel: assert property (p_rel) else $error("relation flags not one-hot");
endmodule : math_slave_coprocessor

// ---- shared/mc_pkg.sv ----
// Constants and types for the slave arithmetic unit
package mc_pkg;
  // Command port indices; byte address is four times the index
  localparam logic [2:0] OPCODE_IDX = 3'h0;
  localparam logic [2:0] RESULT_IDX = 3'h1;
  localparam logic [2:0] BASE_HIGH_IDX = 3'h2;
  localparam logic [2:0] STATUS_IDX = 3'h7;
  // Address bit that selects the operand window
  localparam int WINDOW_BIT = 18;
  localparam logic [7:0] BASE_RESET = 8'h00;
  // Status byte bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  // Error codes in the low bits of the result byte
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_DIV_ZERO = 3'h1;
  localparam logic [2:0] ERR_NEG_ROOT = 3'h2;
  localparam logic [2:0] ERR_OVERFLOW = 3'h3;
  localparam logic [2:0] ERR_UNDERFLOW = 3'h4;
  // Relation flags, bits 7:5 as equal, greater, less
  localparam logic [2:0] REL_EQ = 3'h4;
  localparam logic [2:0] REL_GT = 3'h2;
  localparam logic [2:0] REL_LT = 3'h1;
  // Single precision layout
  localparam int BIAS = 127;
  localparam int FRAC_W = 23;
  localparam int EXP_TOP = 255;
  localparam int INT_TOP_EXP = 30;
  localparam logic [5:0] DIV_LAST = 6'h1f;
  localparam logic [48:0] ROOT_FIRST_BIT = 49'h1_0000_0000_0000;
  typedef enum logic [3:0] {
    int_product_op = 4'h0,
    int_quotient_op = 4'h1,
    real_product_op = 4'h2,
    real_quotient_op = 4'h3,
    real_sum_op = 4'h4,
    real_difference_op = 4'h5,
    real_squaring_op = 4'h6,
    real_root_op = 4'h7,
    int_to_real_op = 4'h8,
    real_to_int_op = 4'h9,
    real_relation_op = 4'ha,
    real_zero_check_op = 4'hb,
    wide_int_quotient_op = 4'he,
    argument_swap_op = 4'hf
  } opcode_t;
  // Longest execution times, microseconds
  localparam int CLK_HZ = 20_000_000;
  localparam int PRODUCT_US = 19;
  localparam int QUOTIENT_US = 28;
  localparam int WIDE_QUOTIENT_US = 94;
  localparam int REAL_PRODUCT_US = 91;
  localparam int REAL_QUOTIENT_US = 102;
  localparam int REAL_SUM_US = 56;
  localparam int SQUARE_US = 91;
  localparam int ROOT_US = 199;
  localparam int TO_REAL_US = 89;
  localparam int TO_INT_US = 81;
  localparam int RELATION_US = 5;
  localparam int SWAP_US = 4;
  // Longest time rounds down to whole cycles
  function automatic int limit_cycles(input opcode_t op);
    int us;
    case (op)
      int_product_op: us = PRODUCT_US;
      int_quotient_op: us = QUOTIENT_US;
      wide_int_quotient_op: us = WIDE_QUOTIENT_US;
      real_product_op: us = REAL_PRODUCT_US;
      real_quotient_op: us = REAL_QUOTIENT_US;
      real_sum_op, real_difference_op: us = REAL_SUM_US;
      real_squaring_op: us = SQUARE_US;
      real_root_op: us = ROOT_US;
      int_to_real_op: us = TO_REAL_US;
      real_to_int_op: us = TO_INT_US;
      real_relation_op, real_zero_check_op: us = RELATION_US;
      default: us = SWAP_US;
    endcase
    return (us * (CLK_HZ / 1_000_000));
  endfunction : limit_cycles
endpackage : mc_pkg

// ---- tb/wb_host_model.sv ----
// Host bus master model that reaches the arithmetic unit over classic Wishbone
`timescale 1ns/1ps
module wb_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [18:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // Idle bus at time zero
  initial begin
    {cyc_o, stb_o, we_o} = 3'h0;
    adr_o = 19'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // -----------------------------------------------------------------
  // Single byte transfer
  // -----------------------------------------------------------------
  // One request per byte, held until ack; released lines carry junk
  // so that a slave sampling them late cannot get a lucky match
  task automatic access(input logic w, input logic [18:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'b11, w};
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i[7:0];
    {cyc_o, stb_o, we_o} <= {2'b00, ~w};
    adr_o <= ~a;
    dat_o <= ~{24'h0, d};
  endtask : access
endmodule : wb_host_model

// ---- tb/math_slave_coprocessor_test.sv ----
// Self-checking bench for the slave arithmetic unit
`timescale 1ns/1ps
module math_slave_coprocessor_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, busy, cpl, err;
  logic [18:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, a, b;
  logic [15:0] d;
  logic [7:0] q;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int bcnt = 0;
  int seed = 37664;

  math_slave_coprocessor u_math_slave_coprocessor (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .busy_o(busy),
    .complete_irq_o(cpl), .error_irq_o(err));
  wb_host_model u_wb_host_model (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  always #25 clk_i = ~clk_i;

  // Busy length counter and hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) begin
      bcnt <= bcnt + 1;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Window base is high 5a, low 30
  function automatic logic [18:0] win(input int loc);
    return {1'b1, 8'h5a, 4'h3, loc[3:0], 2'b00};
  endfunction : win

  function automatic logic [18:0] port(input logic [2:0] idx);
    return {14'h0, idx, 2'b00};
  endfunction : port

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [18:0] adr_w, input logic [7:0] v);
    logic [7:0] unused;
    u_wb_host_model.access(1'b1, adr_w, v, unused);
  endtask : wr

  task automatic rd(input logic [18:0] adr_r, output logic [7:0] v);
    u_wb_host_model.access(1'b0, adr_r, 8'h00, v);
  endtask : rd

  task automatic rd32(input int loc, output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      rd(win(loc + i), v[8*i+:8]);
    end
  endtask : rd32

  // Load, start, wait, then check flags, timing, status, result and both arguments;
  // poke tries an opcode and a window write while busy, both must be ignored
  task automatic run_op(input mc_pkg::opcode_t op, input logic [31:0] a1, input logic [31:0] a2, input int us,
      input logic [31:0] e1, input logic [31:0] e2, input logic [7:0] res, input bit poke);
    logic [31:0] v;
    logic [7:0] s;
    int b0;
    for (int i = 0; i < 4; i++) begin
      wr(win(i), a1[8*i+:8]);
      wr(win(4 + i), a2[8*i+:8]);
    end
    wr(port(mc_pkg::OPCODE_IDX), {4'h0, op});
    #1;
    // Snapshot instead of clearing keeps the counter single-driven
    b0 = bcnt;
    chk({busy, cpl, err}, 3'b100);
    if (poke) begin
      wr(port(mc_pkg::OPCODE_IDX), {4'h0, mc_pkg::argument_swap_op});
      wr(win(0), 8'hff);
    end
    do begin
      @(posedge clk_i);
      #1;
    end while (busy === 1'b1);
    chk({busy, cpl, err}, {1'b0, res[2:0] == 3'h0, res[2:0] != 3'h0});
    chk(bcnt - b0 <= us * (mc_pkg::CLK_HZ / 1_000_000), 1'b1);
    rd(port(mc_pkg::STATUS_IDX), s);
    chk(s, {5'h0, res[2:0] != 3'h0, res[2:0] == 3'h0, 1'b0});
    rd(port(mc_pkg::RESULT_IDX), s);
    chk(s, res);
    rd32(0, v);
    chk(v, e1);
    rd32(4, v);
    chk(v, e2);
  endtask : run_op

  task automatic end_of_test();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(port(mc_pkg::STATUS_IDX), q);
    chk(q, 8'h00);
    rd(port(3'h3), q);
    chk(q, 8'h00);
    wr(port(mc_pkg::RESULT_IDX), 8'h30);
    wr(port(mc_pkg::BASE_HIGH_IDX), 8'h5a);
    rd(win(8), q);
    chk(q, 8'h00);
    // Float, conversion, compare and swap corners, errors leave arguments untouched
    run_op(mc_pkg::real_sum_op, 32'h3f800000, 32'h40000000, 56, 32'h40400000, 32'h40000000, 8'h00, 0);
    run_op(mc_pkg::real_difference_op, 32'h40400000, 32'h3f800000, 56, 32'h40000000, 32'h3f800000, 8'h00, 0);
    run_op(mc_pkg::real_product_op, 32'h40000000, 32'h40400000, 91, 32'h40c00000, 32'h40400000, 8'h00, 0);
    run_op(mc_pkg::real_quotient_op, 32'h40c00000, 32'h40000000, 102, 32'h40400000, 32'h40000000, 8'h00, 0);
    run_op(mc_pkg::real_quotient_op, 32'h3f800000, 32'h0, 102, 32'h3f800000, 32'h0, 8'h01, 0);
    run_op(mc_pkg::real_product_op, 32'h7f000000, 32'h7f000000, 91, 32'h7f000000, 32'h7f000000, 8'h03, 0);
    run_op(mc_pkg::real_product_op, 32'h00800000, 32'h00800000, 91, 32'h00800000, 32'h00800000, 8'h04, 0);
    run_op(mc_pkg::real_squaring_op, 32'h40400000, 32'h0, 91, 32'h41100000, 32'h0, 8'h00, 0);
    run_op(mc_pkg::real_root_op, 32'h40800000, 32'h0, 199, 32'h40000000, 32'h0, 8'h00, 0);
    run_op(mc_pkg::real_root_op, 32'hbf800000, 32'h0, 199, 32'hbf800000, 32'h0, 8'h02, 0);
    run_op(mc_pkg::int_to_real_op, 32'h5, 32'h0, 89, 32'h40a00000, 32'h0, 8'h00, 0);
    run_op(mc_pkg::real_to_int_op, 32'h40a00000, 32'h0, 81, 32'h5, 32'h0, 8'h00, 0);
    run_op(mc_pkg::int_to_real_op, 32'hfffffffb, 32'h0, 89, 32'hc0a00000, 32'h0, 8'h00, 0);
    run_op(mc_pkg::real_to_int_op, 32'hc0a00000, 32'h0, 81, 32'hfffffffb, 32'h0, 8'h00, 0);
    run_op(mc_pkg::real_to_int_op, 32'h4f800000, 32'h0, 81, 32'h4f800000, 32'h0, 8'h03, 0);
    // Undefined opcode ends cleanly and leaves both arguments alone
    run_op(mc_pkg::opcode_t'(4'hc), 32'h1, 32'h2, 4, 32'h1, 32'h2, 8'h00, 0);
    run_op(mc_pkg::real_relation_op, 32'h3f800000, 32'h40000000, 5, 32'h3f800000, 32'h40000000, 8'h20, 0);
    run_op(mc_pkg::real_relation_op, 32'h40000000, 32'h3f800000, 5, 32'h40000000, 32'h3f800000, 8'h40, 0);
    run_op(mc_pkg::real_zero_check_op, 32'h0, 32'h0, 5, 32'h0, 32'h0, 8'h80, 0);
    run_op(mc_pkg::real_zero_check_op, 32'hbf800000, 32'h0, 5, 32'hbf800000, 32'h0, 8'h20, 0);
    run_op(mc_pkg::argument_swap_op, 32'h11223344, 32'h55667788, 4, 32'h55667788, 32'h11223344, 8'h00, 0);
    run_op(mc_pkg::int_quotient_op, 32'h1234, 32'h0, 28, 32'h1234, 32'h0, 8'h01, 0);
    // Random fixed point operands, divisor kept non-zero
    for (int n = 0; n < 6; n++) begin
      a = $random(seed);
      b = $random(seed);
      d = b[15:0] | 16'h1;
      run_op(mc_pkg::int_product_op, {16'h0, a[15:0]}, {16'h0, b[15:0]}, 19, a[15:0] * b[15:0],
        {16'h0, b[15:0]}, 8'h00, 0);
      run_op(mc_pkg::int_quotient_op, {16'h0, a[15:0]}, {16'h0, d}, 28, a[15:0] / d, a[15:0] % d, 8'h00,
        n == 0);
      run_op(mc_pkg::wide_int_quotient_op, a, {16'h0, d}, 94, a / d, a % d, 8'h00, n == 1);
    end
    end_of_test();
  end
endmodule : math_slave_coprocessor_test
